// ==== rtl/rclk_pkg.sv ====
/*
  Package for the reference clock and calibrator block: widths, range
  encoding, reset values and carrier types.
  Assumes a single 100 MHz mclk domain and synchronous active-high reset.
*/
package rclk_pkg;

  localparam int RCLK_DIV_WIDTH = 34;
  localparam int RCLK_RANGE_COUNT = 10;
  localparam int RCLK_RANGE_WIDTH = 4;
  localparam int RCLK_BASE_BITS = 2;
  localparam int RCLK_STEP_BITS = 3;
  localparam int RCLK_MASK_WIDTH = 29;
  localparam logic [RCLK_DIV_WIDTH-1:0] RCLK_DIV_RESET = 34'h0_0000_0000;
  localparam logic [RCLK_RANGE_WIDTH-1:0] RCLK_RANGE_RESET = 4'h0;
  localparam int RCLK_EXT_MHZ = 50;
  localparam int RCLK_MCLK_MHZ = 100;
  localparam int RCLK_HALF_CYCLES = RCLK_MCLK_MHZ / (2 * RCLK_EXT_MHZ);

  typedef enum logic {
    RCLK_SRC_INTERNAL,
    RCLK_SRC_EXTERNAL
  } rclk_src_type;

  typedef struct packed {
    logic main_clk;
    logic spare_clk;
    logic start_spike;
    logic stop_spike;
  } rclk_clocks_type;

  typedef struct packed {
    logic pulse;
    logic [RCLK_RANGE_WIDTH-1:0] range;
  } rclk_cal_type;

endpackage : rclk_pkg

// ==== rtl/rclk_divider.sv ====
/*
  Free-running 34-bit binary divider of the calibrator with range gate.
  Assumes ref_tick is a one-cycle enable marking each reference pulse.
*/
`timescale 1ns/1ps
module rclk_divider
  import rclk_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ref_tick, // Reference pulse enable
  input wire logic [RCLK_RANGE_WIDTH-1:0] range, // Range position 0..9
  output logic slot // Registered output slot flag
);

  logic [RCLK_DIV_WIDTH-1:0] count;
  logic [RCLK_DIV_WIDTH-1:0] next_count;
  logic next_slot;

  function automatic logic [RCLK_DIV_WIDTH-1:0] range_mask(
    input logic [RCLK_RANGE_WIDTH-1:0] pos
  );
    logic [RCLK_DIV_WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < RCLK_DIV_WIDTH; i++) begin
      if (i < RCLK_BASE_BITS + RCLK_STEP_BITS * int'(pos)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : range_mask

  always_comb begin
    next_count = count;
    next_slot = slot;
    if (ref_tick) begin
      next_count = count + 34'h0_0000_0001;
      // Open on the tick taken while the low range bits are all ones, which wraps them to zero
      next_slot = ((count | ~range_mask(range)) == '1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= RCLK_DIV_RESET;
      slot <= 1'b0;
    end else begin
      count <= next_count;
      slot <= next_slot;
    end
  end

endmodule : rclk_divider

// ==== rtl/rclk_clock_module.sv ====
/*
  Clock module: source select, clock distribution and calibrator.
  Assumes the external reference arrives on a pin and is sampled on mclk;
  mclk runs at least twice the reference rate.
*/
`timescale 1ns/1ps
module rclk_clock_module
  import rclk_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic src_sel, // 1 selects the external clock
  input wire logic int_osc, // Internal oscillator level
  input wire logic ext_ref, // External reference pin
  input wire logic [RCLK_RANGE_WIDTH-1:0] cal_range, // Range switch
  output rclk_clocks_type clocks, // Distributed clocks
  output rclk_cal_type cal_out // Calibrator pulse and active range
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Pins cross into mclk through two flops before any logic reads them

  logic [1:0] ext_sync;
  logic [1:0] osc_sync;
  logic [1:0] sel_sync;
  logic [RCLK_RANGE_WIDTH-1:0] range_meta;
  logic [RCLK_RANGE_WIDTH-1:0] range_sync;
  logic ext_prev;
  logic [1:0] next_ext_sync;
  logic [1:0] next_osc_sync;
  logic [1:0] next_sel_sync;
  logic [RCLK_RANGE_WIDTH-1:0] next_range_meta;
  logic [RCLK_RANGE_WIDTH-1:0] next_range_sync;
  logic next_ext_prev;

  // Shift each pin one stage deeper
  always_comb begin
    next_ext_sync = {ext_sync[0], ext_ref};
    next_osc_sync = {osc_sync[0], int_osc};
    next_sel_sync = {sel_sync[0], src_sel};
    next_range_meta = cal_range;
    next_range_sync = range_meta;
    // Only the second flop feeds the edge history
    next_ext_prev = ext_sync[1];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_sync <= 2'h0;
      osc_sync <= 2'h0;
      sel_sync <= 2'h0;
      range_meta <= RCLK_RANGE_RESET;
      range_sync <= RCLK_RANGE_RESET;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= next_ext_sync;
      osc_sync <= next_osc_sync;
      sel_sync <= next_sel_sync;
      range_meta <= next_range_meta;
      range_sync <= next_range_sync;
      ext_prev <= next_ext_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  // Edges are found from the sampled level and its value one cycle back

  // High for one cycle where a sampled waveform goes from low to high
  function automatic logic edge_rise(
    input logic level_now,
    input logic level_before
  );
    logic result;
    result = level_now & ~level_before;
    return result;
  endfunction : edge_rise

  // High for one cycle where a sampled waveform goes from high to low
  function automatic logic edge_fall(
    input logic level_now,
    input logic level_before
  );
    logic result;
    result = ~level_now & level_before;
    return result;
  endfunction : edge_fall

  // Switch positions past the last range act as the shortest range
  function automatic logic [RCLK_RANGE_WIDTH-1:0] clamp_range(
    input logic [RCLK_RANGE_WIDTH-1:0] pos
  );
    logic [RCLK_RANGE_WIDTH-1:0] result;
    result = pos;
    if (pos >= 4'(RCLK_RANGE_COUNT)) begin
      result = RCLK_RANGE_RESET;
    end
    return result;
  endfunction : clamp_range

  ////////////////////////////////////////////////////////////////////////
  // Source select and distribution
  // Spikes come from the selected level against the registered main clock,
  // so they stay in step with it even across a change of source

  logic sel_level;
  logic ext_rise;
  logic ext_fall;
  logic [RCLK_RANGE_WIDTH-1:0] range_active;
  rclk_clocks_type next_clocks;

  // Pick the source, then derive every distributed clock from it
  always_comb begin
    if (sel_sync[1]) begin
      sel_level = ext_sync[1];
    end else begin
      sel_level = osc_sync[1];
    end
    ext_rise = edge_rise(ext_sync[1], ext_prev);
    ext_fall = edge_fall(ext_sync[1], ext_prev);
    range_active = clamp_range(range_sync);
    next_clocks.main_clk = sel_level;
    next_clocks.spare_clk = sel_level;
    next_clocks.start_spike = edge_rise(sel_level, clocks.main_clk);
    next_clocks.stop_spike = edge_rise(sel_level, clocks.main_clk);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clocks.main_clk <= 1'b0;
      clocks.spare_clk <= 1'b0;
      clocks.start_spike <= 1'b0;
      clocks.stop_spike <= 1'b0;
    end else begin
      clocks <= next_clocks;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibrator: counts trailing edges of the external reference only
  // The divider never sees the internal oscillator, whatever source is set

  logic slot;
  logic gate_open;
  logic next_gate_open;

  rclk_divider u_divider (
    .mclk(mclk), // System clock
    .rst(rst), // Synchronous reset
    .ref_tick(ext_fall),
    .range(range_active),
    .slot(slot)
  );

  // Gate follows the slot flag on each trailing edge
  always_comb begin
    next_gate_open = gate_open;
    if (ext_fall) begin
      next_gate_open = slot;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_open <= 1'b0;
    end else begin
      gate_open <= next_gate_open;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibrator output stage
  // Same path length for every range, so the output phase never moves

  logic pulse_start;
  logic pulse_hold;
  rclk_cal_type next_cal;

  // Pulse spans the reference high phase of the gated period
  always_comb begin
    pulse_start = gate_open & ext_rise;
    pulse_hold = gate_open & ext_sync[1] & cal_out.pulse;
    next_cal.range = range_active;
    next_cal.pulse = pulse_start | pulse_hold;
    if (ext_fall) begin
      next_cal.pulse = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_out.pulse <= 1'b0;
      cal_out.range <= RCLK_RANGE_RESET;
    end else begin
      cal_out <= next_cal;
    end
  end

endmodule : rclk_clock_module

// ==== tb/rclk_clock_module_assertions.sv ====
/* Output checks of the clock module.
   Bound to rclk_clock_module; sees its ports only. */
`timescale 1ns/1ps
module rclk_clock_module_assertions
  import rclk_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire rclk_clocks_type clocks, // Clocks
  input wire rclk_cal_type cal_out // Calibrator
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_spare_main: assert property (
    clocks.spare_clk == clocks.main_clk) else $error("spare differs");
  a_spike_rise: assert property (
    clocks.start_spike == $rose(clocks.main_clk)) else $error("spike phase");
  a_spikes_pair: assert property (
    clocks.start_spike == clocks.stop_spike) else $error("spikes differ");
  a_spike_narrow: assert property (
    clocks.start_spike |=> !clocks.start_spike) else $error("spike wide");
  a_pulse_width: assert property (
    cal_out.pulse |=> !cal_out.pulse) else $error("pulse wide");
  a_pulse_gap: assert property (
    cal_out.pulse |=> !cal_out.pulse [*7]) else $error("pulse too soon");
  a_range_valid: assert property (
    cal_out.range < 4'hA) else $error("range out of span");
  a_quiet_reset: assert property (
    $past(rst) |-> !cal_out.pulse && !clocks.main_clk) else $error("reset");
  cover property (cal_out.pulse);
  cover property (clocks.start_spike);
  cover property (cal_out.pulse && cal_out.range == 4'h3);
endmodule : rclk_clock_module_assertions

// ==== tb/rclk_digitizer_model.sv ====
/* Start and stop inputs of the digitizer, both fed by one line.
   Assumes single-cycle pulses on mclk. */
`timescale 1ns/1ps
module rclk_digitizer_model (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic start_in, // Start input
  input wire logic stop_in, // Stop input
  output logic [31:0] interval, // Cycles start to stop
  output logic done // Interval ready
);
  logic busy;
  logic [31:0] cnt;
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 32'h0000_0000;
      interval <= 32'h0000_0000;
    end else if (!busy) begin
      busy <= start_in;
      cnt <= 32'h0000_0001;
    end else if (stop_in) begin
      interval <= cnt;
      done <= 1'b1;
      busy <= 1'b0;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end
endmodule : rclk_digitizer_model

// ==== tb/reference_clock_and_calibrator_tb_top.sv ====
/* Bench of the clock module with calibrator.
   Assumes a 100 MHz mclk and a clean 50 MHz reference. */
`timescale 1ns/1ps
module reference_clock_and_calibrator_tb_top;
  import rclk_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic src_sel = 1'b0;
  logic int_osc = 1'b0;
  logic ext_ref = 1'b0;
  logic ph = 1'b0;
  logic [RCLK_RANGE_WIDTH-1:0] cal_range = 4'h0;
  rclk_clocks_type clocks;
  rclk_cal_type cal_out;
  logic [31:0] interval;
  logic done;
  int mismatches = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  always @(negedge mclk) begin
    ext_ref <= ~ext_ref;
    ph <= ~ph;
    if (ph) int_osc <= ~int_osc;
  end
  rclk_clock_module uut (.mclk(mclk), .rst(rst), .src_sel(src_sel),
    .int_osc(int_osc), .ext_ref(ext_ref), .cal_range(cal_range),
    .clocks(clocks), .cal_out(cal_out));
  rclk_digitizer_model partner (.mclk(mclk), .rst(rst),
    .start_in(cal_out.pulse), .stop_in(cal_out.pulse),
    .interval(interval), .done(done));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %0d expected %0d", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wait_done;
    for (int i = 0; i < 40000 && done !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
  endtask : wait_done
  task automatic test_source(input logic sel, input int exp);
    int rises;
    int spikes;
    logic prev;
    src_sel = sel;
    repeat (12) @(negedge mclk);
    rises = 0;
    spikes = 0;
    prev = clocks.main_clk;
    repeat (40) begin
      @(negedge mclk);
      if (clocks.main_clk && !prev) rises++;
      if (clocks.start_spike) spikes++;
      prev = clocks.main_clk;
    end
    check(rises, exp);
    check(spikes, exp);
  endtask : test_source
  task automatic test_range(input logic [3:0] r, input int sh);
    cal_range = r;
    repeat (16) @(negedge mclk);
    wait_done();
    wait_done();
    check(interval, 32'h0000_0001 << sh);
    if (r < 4'hA) check(32'(cal_out.range), 32'(r));
    else check(32'(cal_out.range), 32'h0000_0000);
  endtask : test_range
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    test_source(1'b1, 20);
    test_source(1'b0, 10);
    test_range(4'h0, 3);
    test_range(4'h2, 9);
    test_range(4'h1, 6);
    test_range(4'h3, 12);
    test_range(4'hA, 3);
    finish_test();
  end
  initial begin
    #600000;
    mismatches++;
    finish_test();
  end
endmodule : reference_clock_and_calibrator_tb_top
bind rclk_clock_module rclk_clock_module_assertions u_chk (.mclk(mclk),
  .rst(rst), .clocks(clocks), .cal_out(cal_out));
